//--- srw_host_model.sv
// behavioural host that drives the 3-wire serial write port
`timescale 1ns/1ps
`default_nettype none
module srw_host_model (
	output logic serial_clock,
	output logic serial_data,
	output logic load_select_line
);
	// idle: link clock parked low, select high
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		load_select_line = 1'b1;
	end
	// 12 address bits then nbits of payload, both lsb first; a short count aborts mid-word
	task automatic frame(input logic [11:0] addr, input logic [55:0] payload, input int nbits);
		logic [67:0] bits;
		bits = {payload, addr};
		// start a quarter period off the bench clock edges so no pin races its sampler
		#($urandom_range(1, 3) * 50 + 25 - int'($time % 50));
		load_select_line = 1'b0;
		for (int i = 0; i < 12 + nbits; i++) begin
			serial_data = bits[i];
			#400 serial_clock = 1'b1;
			#400 serial_clock = 1'b0;
		end
		#400 load_select_line = 1'b1;
		// released data line shows the inverse so stale bits cannot pass
		serial_data = ~serial_data;
		#400;
	endtask
endmodule
`default_nettype wire

//--- srw_pkg.sv
// constants and types shared by the serial register write and update block
package srw_pkg;
	// ========================================
	// frame layout
	localparam int unsigned ADDR_W     = 12;
	localparam int unsigned DATA_W     = 28;
	localparam int unsigned BIT_CNT_W  = 6;
	localparam logic [BIT_CNT_W-1:0] ADDR_BITS = 6'h0C;
	localparam logic [BIT_CNT_W-1:0] DATA_BITS = 6'h1C;

	// ========================================
	// register map
	localparam logic [ADDR_W-1:0] REG_SYNC_UPDATE_DELAY  = 12'h018;
	localparam logic [ADDR_W-1:0] REG_PATTERN_GROUP_CNT  = 12'h090;
	localparam logic [ADDR_W-1:0] REG_SEQUENCE_CNT       = 12'h091;
	localparam logic [ADDR_W-1:0] FIXED_AREA_LAST        = 12'h091;
	localparam logic [ADDR_W-1:0] PATTERN_AREA_BASE      = 12'h400;
	localparam logic [5:0]        PATTERN_GROUP_SPAN     = 6'h28;
	localparam logic [5:0]        SEQUENCE_SPAN          = 6'h14;
	localparam logic [5:0]        FIELD_SPAN             = 6'h0C;
	localparam logic [ADDR_W-1:0] IMMEDIATE_LOW_LAST     = 12'h003;
	localparam logic [ADDR_W-1:0] IMMEDIATE_SOFT_RESET   = 12'h010;
	localparam logic [ADDR_W-1:0] GATE_LINE_FIRST        = 12'h070;
	localparam logic [ADDR_W-1:0] GATE_LINE_LAST         = 12'h07F;
	localparam logic [DATA_W-1:0] COUNT_RESET            = 28'h0000000;

	// ========================================
	// deferred write table
	localparam int unsigned PEND_DEPTH = 8;
	localparam int unsigned PEND_IDX_W = 3;

	typedef enum logic [3:0] {
		SRW_UPD_IMMEDIATE = 4'b0001,
		SRW_UPD_FRAME     = 4'b0010,
		SRW_UPD_GATE_LINE = 4'b0100,
		SRW_UPD_SEQ_CHG   = 4'b1000
	} srw_update_kind_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} srw_write_t;

	typedef struct packed {
		logic             valid;
		logic             due;
		logic             no_delay;
		srw_update_kind_t kind;
		srw_write_t       wr;
	} srw_pending_t;
endpackage

//--- srw_serial_rx.sv
// serial receiver: samples the 3-wire port and emits complete register words
`timescale 1ns/1ps
`default_nettype none
module srw_serial_rx (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               serial_clock,
	input  wire logic               serial_data,
	input  wire logic               load_select_line,
	output logic                    word_valid,
	output srw_pkg::srw_write_t     word
);
	import srw_pkg::*;

	// ========================================
	// pin synchronisers
	logic [1:0]              sclk_sync;
	logic [1:0]              sdata_sync;
	logic [1:0]              sl_sync;
	logic                    sclk_prev;
	logic                    sclk_rise;
	logic                    in_frame;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclk_sync  <= 2'h0;
			sdata_sync <= 2'h0;
			sl_sync    <= 2'h3;
			sclk_prev  <= 1'b0;
		end else begin
			sclk_sync  <= {sclk_sync[0], serial_clock};
			sdata_sync <= {sdata_sync[0], serial_data};
			sl_sync    <= {sl_sync[0], load_select_line};
			sclk_prev  <= sclk_sync[1];
		end
	end

	assign sclk_rise = sclk_sync[1] & ~sclk_prev;
	assign in_frame  = ~sl_sync[1];

	// ========================================
	// shifting and word assembly
	logic [BIT_CNT_W-1:0]    bit_cnt;
	logic                    addr_done;
	logic [ADDR_W-1:0]       addr_shift;
	logic [ADDR_W-1:0]       addr_ctr;
	logic [DATA_W-1:0]       data_shift;
	logic                    last_bit;

	assign last_bit = addr_done && (bit_cnt == DATA_BITS - 6'h01);

	// a frame closed early simply drops the bit count and address phase, so no partial word escapes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bit_cnt    <= 6'h00;
			addr_done  <= 1'b0;
			addr_shift <= 12'h000;
			addr_ctr   <= 12'h000;
			data_shift <= 28'h0000000;
		end else if (!in_frame) begin
			bit_cnt   <= 6'h00;
			addr_done <= 1'b0;
		end else if (sclk_rise) begin
			if (!addr_done) begin
				addr_shift <= {sdata_sync[1], addr_shift[ADDR_W-1:1]};
				if (bit_cnt == ADDR_BITS - 6'h01) begin
					addr_done <= 1'b1;
					bit_cnt   <= 6'h00;
					addr_ctr  <= {sdata_sync[1], addr_shift[ADDR_W-1:1]};
				end else begin
					bit_cnt <= bit_cnt + 6'h01;
				end
			end else begin
				data_shift <= {sdata_sync[1], data_shift[DATA_W-1:1]};
				if (last_bit) begin
					bit_cnt  <= 6'h00;
					addr_ctr <= addr_ctr + 12'h001;
				end else begin
					bit_cnt <= bit_cnt + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			word_valid <= 1'b0;
			word       <= '0;
		end else begin
			word_valid <= in_frame && sclk_rise && last_bit;
			if (in_frame && sclk_rise && last_bit) begin
				word.addr <= addr_ctr;
				word.data <= {sdata_sync[1], data_shift[DATA_W-1:1]};
			end
		end
	end
endmodule
`default_nettype wire

//--- srw_update.sv
// serial register write port with update timing for a configurable register space
`timescale 1ns/1ps
`default_nettype none
module srw_update (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               serial_clock,
	input  wire logic               serial_data,
	input  wire logic               load_select_line,
	input  wire logic               vertical_sync,
	input  wire logic               horizontal_sync,
	input  wire logic               sensor_gate_line,
	input  wire logic               sequence_change_position,
	output logic                    apply_valid,
	output srw_pkg::srw_write_t     apply,
	output logic [27:0]             sync_update_delay,
	output logic [27:0]             pattern_group_count,
	output logic [27:0]             sequence_count,
	output logic [11:0]             sequence_area_base,
	output logic [11:0]             field_area_base,
	output logic                    pending_overflow
);
	import srw_pkg::*;

	// ========================================
	// serial receiver
	logic       word_valid;
	srw_write_t word;

	srw_serial_rx u_rx (
		.clk              (clk),
		.reset            (reset),
		.serial_clock     (serial_clock),
		.serial_data      (serial_data),
		.load_select_line (load_select_line),
		.word_valid       (word_valid),
		.word             (word)
	);

	// ========================================
	// area placement
	logic [17:0] pattern_span_total;
	logic [17:0] sequence_span_total;

	// counts wider than the address space wrap; the host keeps them sensible
	assign pattern_span_total  = pattern_group_count[11:0] * PATTERN_GROUP_SPAN;
	assign sequence_span_total = sequence_count[11:0] * SEQUENCE_SPAN;
	assign sequence_area_base  = PATTERN_AREA_BASE + pattern_span_total[11:0];
	assign field_area_base     = sequence_area_base + sequence_span_total[11:0];

	// ========================================
	// update kind of the incoming word
	srw_update_kind_t word_kind;
	logic             word_is_field;

	always_comb begin
		word_is_field = 1'b0;
		if (word.addr >= PATTERN_AREA_BASE) begin
			if (word.addr >= field_area_base) begin
				word_kind     = SRW_UPD_FRAME;
				word_is_field = 1'b1;
			end else begin
				word_kind = SRW_UPD_SEQ_CHG;
			end
		end else if (word.addr <= IMMEDIATE_LOW_LAST || word.addr == IMMEDIATE_SOFT_RESET
				|| word.addr > FIXED_AREA_LAST) begin
			word_kind = SRW_UPD_IMMEDIATE;
		end else if (word.addr >= GATE_LINE_FIRST && word.addr <= GATE_LINE_LAST) begin
			word_kind = SRW_UPD_GATE_LINE;
		end else begin
			word_kind = SRW_UPD_FRAME;
		end
	end

	// ========================================
	// timing events
	logic        vsync_prev;
	logic        hsync_prev;
	logic        vsync_fall;
	logic        hsync_fall;
	logic        gate_seen;
	logic        line_wait;
	logic [27:0] line_cnt;
	logic        frame_due;
	logic        field_due;
	logic        gate_due;

	assign vsync_fall = vsync_prev & ~vertical_sync;
	assign hsync_fall = hsync_prev & ~horizontal_sync;
	assign field_due  = vsync_fall;
	assign gate_due   = hsync_fall & gate_seen;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vsync_prev <= 1'b0;
			hsync_prev <= 1'b0;
		end else begin
			vsync_prev <= vertical_sync;
			hsync_prev <= horizontal_sync;
		end
	end

	// gate line is remembered until the line's closing sync edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gate_seen <= 1'b0;
		end else if (sensor_gate_line) begin
			gate_seen <= 1'b1;
		end else if (hsync_fall) begin
			gate_seen <= 1'b0;
		end
	end

	// lines are counted from the sync fall; a zero delay releases at the fall
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			line_wait <= 1'b0;
			line_cnt  <= 28'h0000000;
		end else if (vsync_fall) begin
			line_wait <= (sync_update_delay != 28'h0000000);
			line_cnt  <= 28'h0000000;
		end else if (line_wait && hsync_fall) begin
			line_cnt <= line_cnt + 28'h0000001;
			if (line_cnt + 28'h0000001 == sync_update_delay) begin
				line_wait <= 1'b0;
			end
		end
	end

	always_comb begin
		if (sync_update_delay == 28'h0000000) begin
			frame_due = vsync_fall;
		end else begin
			frame_due = line_wait && hsync_fall && (line_cnt + 28'h0000001 == sync_update_delay);
		end
	end

	// ========================================
	// deferred write table
	srw_pending_t                  pend [PEND_DEPTH];
	logic [PEND_DEPTH-1:0]         hit_vec;
	logic [PEND_DEPTH-1:0]         free_vec;
	logic [PEND_DEPTH-1:0]         due_vec;
	logic [PEND_IDX_W-1:0]         ins_idx;
	logic [PEND_IDX_W-1:0]         rel_idx;
	logic                          ins_hit;
	logic                          ins_free;
	logic                          rel_any;
	logic                          store;
	logic                          release_now;

	assign store       = word_valid && (word_kind != SRW_UPD_IMMEDIATE);
	assign release_now = rel_any && !(word_valid && word_kind == SRW_UPD_IMMEDIATE);

	always_comb begin
		ins_idx  = '0;
		rel_idx  = '0;
		ins_hit  = 1'b0;
		ins_free = 1'b0;
		rel_any  = 1'b0;
		for (int i = PEND_DEPTH - 1; i >= 0; i--) begin
			if (free_vec[i] && !ins_hit) begin
				ins_idx  = PEND_IDX_W'(i);
				ins_free = 1'b1;
			end
			if (due_vec[i]) begin
				rel_idx = PEND_IDX_W'(i);
				rel_any = 1'b1;
			end
		end
		for (int i = PEND_DEPTH - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				ins_idx = PEND_IDX_W'(i);
				ins_hit = 1'b1;
			end
		end
	end

	generate
		for (genvar g = 0; g < PEND_DEPTH; g++) begin : g_pend
			logic ev;
			logic put;
			assign hit_vec[g]  = pend[g].valid && !pend[g].due && pend[g].wr.addr == word.addr;
			assign free_vec[g] = !pend[g].valid;
			assign due_vec[g]  = pend[g].valid && pend[g].due;
			assign put         = store && (ins_hit || ins_free) && ins_idx == PEND_IDX_W'(g);

			always_comb begin
				unique case (pend[g].kind)
					SRW_UPD_FRAME:     ev = pend[g].no_delay ? field_due : frame_due;
					SRW_UPD_GATE_LINE: ev = gate_due;
					SRW_UPD_SEQ_CHG:   ev = sequence_change_position;
					default:           ev = 1'b0;
				endcase
			end

			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					pend[g] <= '0;
				end else if (put) begin
					pend[g].valid    <= 1'b1;
					pend[g].due      <= 1'b0;
					pend[g].no_delay <= word_is_field;
					pend[g].kind     <= word_kind;
					pend[g].wr       <= word;
				end else if (release_now && rel_idx == PEND_IDX_W'(g)) begin
					pend[g].valid <= 1'b0;
				end else if (pend[g].valid && ev) begin
					pend[g].due <= 1'b1;
				end
			end
		end
	endgenerate

	// sticky: a full table loses the word unless an entry not yet due holds its address, so software must re-plan its writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pending_overflow <= 1'b0;
		end else if (store && !ins_hit && !ins_free) begin
			pending_overflow <= 1'b1;
		end
	end

	// ========================================
	// apply port and local registers
	srw_write_t next_apply;
	logic       next_apply_valid;

	always_comb begin
		next_apply_valid = 1'b0;
		// the apply port holds its last word between pulses
		next_apply       = apply;
		if (word_valid && word_kind == SRW_UPD_IMMEDIATE) begin
			next_apply_valid = 1'b1;
			next_apply       = word;
		end else if (rel_any) begin
			next_apply_valid = 1'b1;
			next_apply       = pend[rel_idx].wr;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			apply_valid <= 1'b0;
			apply       <= '0;
		end else begin
			apply_valid <= next_apply_valid;
			apply       <= next_apply;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_update_delay   <= COUNT_RESET;
			pattern_group_count <= COUNT_RESET;
			sequence_count      <= COUNT_RESET;
		end else if (next_apply_valid) begin
			if (next_apply.addr == REG_SYNC_UPDATE_DELAY) begin
				sync_update_delay <= next_apply.data;
			end
			if (next_apply.addr == REG_PATTERN_GROUP_CNT) begin
				pattern_group_count <= next_apply.data;
			end
			if (next_apply.addr == REG_SEQUENCE_CNT) begin
				sequence_count <= next_apply.data;
			end
		end
	end
endmodule
`default_nettype wire

//--- srw_update_chk.sv
// concurrent checks on the ports of the serial register write and update block
`timescale 1ns/1ps
`default_nettype none
module srw_update_chk (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                serial_clock,
	input  wire logic                serial_data,
	input  wire logic                load_select_line,
	input  wire logic                vertical_sync,
	input  wire logic                horizontal_sync,
	input  wire logic                sensor_gate_line,
	input  wire logic                sequence_change_position,
	input  wire logic                apply_valid,
	input  wire srw_pkg::srw_write_t apply,
	input  wire logic [27:0]         sync_update_delay,
	input  wire logic [27:0]         pattern_group_count,
	input  wire logic [27:0]         sequence_count,
	input  wire logic [11:0]         sequence_area_base,
	input  wire logic [11:0]         field_area_base,
	input  wire logic                pending_overflow
);
	import srw_pkg::*;
	// ========================================
	// cycles since each event, saturating so old events never look fresh
	logic [3:0] since_v, since_h, since_s, since_k;
	logic       prev_v, prev_h, prev_k;
	wire [11:0] ap_addr = apply.addr;
	wire        imm = ap_addr <= IMMEDIATE_LOW_LAST || ap_addr == IMMEDIATE_SOFT_RESET;
	wire        gate = ap_addr >= GATE_LINE_FIRST && ap_addr <= GATE_LINE_LAST;
	wire        frm = ap_addr <= FIXED_AREA_LAST && !imm && !gate;
	function automatic logic [3:0] step(input logic ev, input logic [3:0] c);
		return ev ? 4'h0 : (c == 4'hF ? c : c + 4'h1);
	endfunction
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			{prev_v, prev_h, prev_k} <= 3'b110;
			{since_v, since_h, since_s, since_k} <= 16'hFFFF;
		end else begin
			{prev_v, prev_h, prev_k} <= {vertical_sync, horizontal_sync, serial_clock};
			since_v <= step(prev_v & ~vertical_sync, since_v);
			since_h <= step(prev_h & ~horizontal_sync, since_h);
			since_s <= step(sequence_change_position, since_s);
			since_k <= step(~prev_k & serial_clock, since_k);
		end
	end
	// ========================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	seq_base_a: assert property (sequence_area_base == 12'h400 + 12'(40 * pattern_group_count[11:0]))
		else $error("sequence area base wrong");
	field_base_a: assert property (field_area_base == sequence_area_base + 12'(20 * sequence_count[11:0]))
		else $error("field area base wrong");
	apply_hold_a: assert property (!apply_valid |-> $stable(apply))
		else $error("apply changed without a pulse");
	group_write_a: assert property (apply_valid && ap_addr == REG_PATTERN_GROUP_CNT |=> pattern_group_count == $past(apply.data))
		else $error("group count not taken");
	delay_write_a: assert property (apply_valid && ap_addr == REG_SYNC_UPDATE_DELAY |=> sync_update_delay == $past(apply.data))
		else $error("delay register not taken");
	imm_time_a: assert property (apply_valid && imm |-> since_k <= 4'h6)
		else $error("immediate write late");
	gate_time_a: assert property (apply_valid && gate |-> since_h <= 4'hC)
		else $error("gate write off its line edge");
	frame_time_a: assert property (apply_valid && frm |-> since_v <= 4'hC || since_h <= 4'hC)
		else $error("frame write off its sync edge");
	seq_time_a: assert property (apply_valid && ap_addr >= PATTERN_AREA_BASE && ap_addr < field_area_base |-> since_s <= 4'hC)
		else $error("sequence write off its change");
	field_time_a: assert property (apply_valid && ap_addr >= field_area_base |-> since_v <= 4'hC)
		else $error("field write off its sync edge");
	imm_c: cover property (apply_valid && imm);
	gate_c: cover property (apply_valid && gate);
	seq_c: cover property (apply_valid && since_s <= 4'hC);
endmodule
bind srw_update srw_update_chk chk (.clk, .reset, .serial_clock, .serial_data, .load_select_line, .vertical_sync,
	.horizontal_sync, .sensor_gate_line, .sequence_change_position, .apply_valid, .apply, .sync_update_delay,
	.pattern_group_count, .sequence_count, .sequence_area_base, .field_area_base, .pending_overflow);
`default_nettype wire

//--- test_srw_update.sv
// self-checking testbench for the serial register write and update block
`timescale 1ns/1ps
`default_nettype none
module test_srw_update;
	import srw_pkg::*;
	logic        clk, reset, vertical_sync, horizontal_sync, sensor_gate_line, sequence_change_position;
	logic        serial_clock, serial_data, load_select_line, apply_valid, pending_overflow;
	srw_write_t  apply;
	logic [27:0] sync_update_delay, pattern_group_count, sequence_count, d1, d2, p, s;
	logic [11:0] sequence_area_base, field_area_base, a;
	int          error_cnt, checks, r;
	srw_host_model host (.serial_clock, .serial_data, .load_select_line);
	srw_update DUT (.clk, .reset, .serial_clock, .serial_data, .load_select_line, .vertical_sync, .horizontal_sync,
		.sensor_gate_line, .sequence_change_position, .apply_valid, .apply, .sync_update_delay,
		.pattern_group_count, .sequence_count, .sequence_area_base, .field_area_base, .pending_overflow);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ========================================
	// expectations and shared checks
	function automatic logic [11:0] sb(input logic [27:0] pg);
		return 12'h400 + 12'(40 * pg[11:0]);
	endfunction
	function automatic logic [11:0] fb(input logic [27:0] pg, input logic [27:0] sq);
		return sb(pg) + 12'(20 * sq[11:0]);
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic wait_apply(input logic [11:0] wa, input logic [27:0] wd);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (apply_valid !== 1'b1 && n < 1500);
		if (n >= 1500) begin
			error_cnt++;
			$display("mismatch at %0t: no apply pulse", $time);
			wrap_up();
		end else begin
			check(apply === {wa, wd}, "apply word");
		end
	endtask
	task automatic quiet(input int n);
		repeat (n) begin
			@(negedge clk);
			check(apply_valid === 1'b0, "unexpected apply");
		end
	endtask
	task automatic wr(input logic [11:0] wa, input logic [27:0] wd);
		host.frame(wa, {28'h0000000, wd}, 28);
	endtask
	// k: 0 vertical fall, 1 horizontal fall, 2 sequence change
	task automatic ev(input int k);
		@(posedge clk);
		case (k)
			0: vertical_sync <= 1'b0;
			1: horizontal_sync <= 1'b0;
			default: sequence_change_position <= 1'b1;
		endcase
		@(posedge clk);
		vertical_sync <= 1'b1;
		horizontal_sync <= 1'b1;
		sequence_change_position <= 1'b0;
	endtask
	// ========================================
	// main sequence
	initial begin
		reset = 1'b1;
		vertical_sync = 1'b1;
		horizontal_sync = 1'b1;
		sensor_gate_line = 1'b0;
		sequence_change_position = 1'b0;
		error_cnt = 0;
		checks = 0;
		r = $urandom(32'hA2B1);
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check(apply_valid === 1'b0 && apply === '0 && pending_overflow === 1'b0, "reset outputs");
		check(pattern_group_count === '0 && sequence_count === '0 && sync_update_delay === '0, "reset regs");
		check(sequence_area_base === 12'h400 && field_area_base === 12'h400, "reset bases");
		d1 = 28'($urandom);
		d2 = 28'($urandom);
		fork
			wr(12'h001, d1);
			wait_apply(12'h001, d1);
		join
		fork
			host.frame(12'h002, {d2, d1}, 56);
			begin
				wait_apply(12'h002, d1);
				wait_apply(12'h003, d2);
			end
		join
		fork
			host.frame(12'h000, {d2, d1}, 40);
			begin
				wait_apply(12'h000, d1);
				quiet(120);
			end
		join
		p = 28'($urandom_range(1, 6));
		s = 28'($urandom_range(1, 6));
		host.frame(REG_PATTERN_GROUP_CNT, {s, p}, 56);
		quiet(10);
		ev(0);
		wait_apply(REG_PATTERN_GROUP_CNT, p);
		wait_apply(REG_SEQUENCE_CNT, s);
		@(negedge clk);
		check(pattern_group_count === p && sequence_count === s, "counts");
		check(sequence_area_base === sb(p) && field_area_base === fb(p, s), "area bases");
		wr(REG_SYNC_UPDATE_DELAY, 28'h0000002);
		ev(0);
		wait_apply(REG_SYNC_UPDATE_DELAY, 28'h0000002);
		wr(12'h004, d1);
		wr(fb(p, s), d2);
		ev(0);
		wait_apply(fb(p, s), d2);
		quiet(10);
		ev(1);
		quiet(10);
		ev(1);
		wait_apply(12'h004, d1);
		a = GATE_LINE_FIRST + 12'($urandom_range(0, 15));
		wr(a, d2);
		ev(1);
		quiet(10);
		@(posedge clk);
		sensor_gate_line <= 1'b1;
		repeat (5) @(posedge clk);
		ev(1);
		sensor_gate_line <= 1'b0;
		wait_apply(a, d2);
		a = PATTERN_AREA_BASE + 12'($urandom_range(0, 59));
		wr(a, d1);
		wr(a, d2);
		quiet(5);
		ev(2);
		wait_apply(a, d2);
		quiet(20);
		// nine deferred words against an eight-entry table: the last one is lost
		for (int i = 0; i < 9; i++) begin
			wr(PATTERN_AREA_BASE + 12'(i), d1 ^ 28'(i));
		end
		check(pending_overflow === 1'b1, "overflow flag");
		ev(2);
		for (int i = 0; i < 8; i++) begin
			wait_apply(PATTERN_AREA_BASE + 12'(i), d1 ^ 28'(i));
		end
		quiet(20);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check(pending_overflow === 1'b0 && apply_valid === 1'b0 && apply === '0, "mid-run reset outputs");
		check(pattern_group_count === '0 && field_area_base === 12'h400, "mid-run reset regs");
		fork
			wr(12'h001, d2);
			wait_apply(12'h001, d2);
		join
		wrap_up();
	end
endmodule
`default_nettype wire
